// >>> common/usp_pkg.sv
package usp_pkg;

   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 25;
   localparam int T_CSS_NS = 100;
   localparam int T_CSW_NS = 500;
   localparam int T_SDS_NS = 100;
   localparam int T_INT_NS = 200;
   localparam int CSS_CYC = (T_CSS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CSW_CYC = (T_CSW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HALF_CYC = (T_SDS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int INT_CYC = (T_INT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] CSS_TMR = 8'(CSS_CYC - 1);
   localparam logic [7:0] CSW_TMR = 8'(CSW_CYC - 1);
   localparam logic [7:0] HALF_TMR = 8'(HALF_CYC - 1);
   localparam logic [3:0] INT_TMR = 4'(INT_CYC);

   // ****************************************
   // frame and command layout
   // ****************************************
   localparam int BYTE_W = 8;
   localparam int ADDR_W = 3;
   localparam int NREG = 8;
   localparam int CMD_REG_BIT = 4;
   localparam int CMD_WR_BIT = 3;
   localparam logic [4:0] CNT_CMD_LAST = 5'h07;
   localparam logic [4:0] CNT_DATA_FIRST = 5'h08;
   localparam logic [4:0] CNT_LAST = 5'h0F;
   localparam logic [4:0] CNT_FULL = 5'h10;

   function automatic logic cmd_valid(input logic [7:0] c);
      return c[7:5] == 3'h0;
   endfunction

   function automatic logic cmd_is_write(input logic [7:0] c);
      return c[CMD_WR_BIT];
   endfunction

   // ****************************************
   // host sequencer states
   // ****************************************
   typedef enum logic [4:0] {
      HS_IDLE = 5'h01,
      HS_SETUP = 5'h02,
      HS_SHIFT = 5'h04,
      HS_HOLD = 5'h08,
      HS_GAP = 5'h10
   } usp_hstate_type;

endpackage

// >>> common/usp_if.sv
`timescale 1ns/1ps
interface usp_if;

   // ****************************************
   // link wires
   // ****************************************
   logic scs_n;
   logic sck;
   logic sdi;
   logic sdo;
   logic sdo_oe;
   logic int_n;
   logic sdo_line;

   // undriven output line reads high
   assign sdo_line = sdo_oe ? sdo : 1'b1;

   modport dev (
      input scs_n,
      input sck,
      input sdi,
      output sdo,
      output sdo_oe,
      output int_n
   );

   modport host (
      output scs_n,
      output sck,
      output sdi,
      input sdo_line,
      input int_n
   );

endinterface

// >>> hdl/usp_dev_end.sv
`timescale 1ns/1ps
module usp_dev_end (
   // system clock and reset
   input wire logic clk,
   input wire logic reset,
   // link to the host
   usp_if.dev link,
   // access strobes toward the transceiver core
   output logic wr_stb,
   output logic rd_stb,
   output logic acc_reg,
   output logic [usp_pkg::ADDR_W-1:0] acc_addr,
   output logic [usp_pkg::BYTE_W-1:0] wr_data,
   // readable state from the transceiver core
   input wire logic [usp_pkg::NREG*usp_pkg::BYTE_W-1:0] rd_regs,
   input wire logic [usp_pkg::BYTE_W-1:0] rd_fifo,
   input wire logic core_evt
);
   import usp_pkg::*;

   // ****************************************
   // declarations
   // ****************************************
   logic [4:0] cnt_r;
   logic [4:0] cnt_nxt;
   logic [15:0] shf_r;
   logic [15:0] shf_nxt;
   logic rd_act_r;
   logic rd_act_nxt;
   logic [7:0] rd_byte_r;
   logic [7:0] rd_byte_nxt;
   logic [7:0] cmd_now;
   logic tgl_r;
   logic tgl_nxt;
   logic [7:0] cmd_r;
   logic [7:0] cmd_nxt;
   logic [7:0] dat_r;
   logic [7:0] dat_nxt;
   logic sdo_r;
   logic sdo_nxt;
   logic oe_r;
   logic oe_nxt;
   logic scs_s1_r;
   logic scs_s2_r;
   logic tgl_s1_r;
   logic tgl_s2_r;
   logic seen_r;
   logic seen_nxt;
   logic [7:0] snap_r [0:NREG-1];
   logic [7:0] snap_nxt [0:NREG-1];
   logic [7:0] fifo_snap_r;
   logic [7:0] fifo_snap_nxt;
   logic wr_stb_r;
   logic wr_stb_nxt;
   logic rd_stb_r;
   logic rd_stb_nxt;
   logic acc_reg_r;
   logic acc_reg_nxt;
   logic [ADDR_W-1:0] acc_addr_r;
   logic [ADDR_W-1:0] acc_addr_nxt;
   logic [7:0] wr_data_r;
   logic [7:0] wr_data_nxt;
   logic [3:0] int_cnt_r;
   logic [3:0] int_cnt_nxt;
   logic int_n_r;
   logic int_n_nxt;
   logic exec;

   // ****************************************
   // link side: shift in on rising edge
   // ****************************************
   assign cmd_now = {shf_r[6:0], link.sdi};

   always_comb begin
      cnt_nxt = cnt_r;
      shf_nxt = shf_r;
      rd_act_nxt = rd_act_r;
      rd_byte_nxt = rd_byte_r;
      if (cnt_r < CNT_FULL) begin
         cnt_nxt = cnt_r + 5'h01;
         shf_nxt = {shf_r[14:0], link.sdi};
         if (cnt_r == CNT_CMD_LAST) begin
            rd_act_nxt = cmd_valid(cmd_now) && !cmd_is_write(cmd_now);
            if (!cmd_valid(cmd_now)) begin
               rd_byte_nxt = 8'h00;
            end else if (cmd_now[CMD_REG_BIT]) begin
               rd_byte_nxt = snap_r[cmd_now[ADDR_W-1:0]];
            end else begin
               rd_byte_nxt = fifo_snap_r;
            end
         end
      end
   end

   // select high clears the frame state at once
   always_ff @(posedge link.sck or posedge link.scs_n) begin
      if (link.scs_n) begin
         cnt_r <= 5'h00;
         shf_r <= 16'h0000;
         rd_act_r <= 1'b0;
         rd_byte_r <= 8'h00;
      end else begin
         cnt_r <= cnt_nxt;
         shf_r <= shf_nxt;
         rd_act_r <= rd_act_nxt;
         rd_byte_r <= rd_byte_nxt;
      end
   end

   // ****************************************
   // link side: complete frame capture
   // ****************************************
   always_comb begin
      tgl_nxt = tgl_r;
      cmd_nxt = cmd_r;
      dat_nxt = dat_r;
      if (!link.scs_n && cnt_r == CNT_LAST) begin
         tgl_nxt = ~tgl_r;
         cmd_nxt = shf_r[14:7];
         dat_nxt = {shf_r[6:0], link.sdi};
      end
   end

   always_ff @(posedge link.sck or posedge reset) begin
      if (reset) begin
         tgl_r <= 1'b0;
         cmd_r <= 8'h00;
         dat_r <= 8'h00;
      end else begin
         tgl_r <= tgl_nxt;
         cmd_r <= cmd_nxt;
         dat_r <= dat_nxt;
      end
   end

   // ****************************************
   // link side: shift out on falling edge
   // ****************************************
   always_comb begin
      oe_nxt = 1'b1;
      sdo_nxt = 1'b0;
      if (rd_act_r && cnt_r >= CNT_DATA_FIRST && cnt_r < CNT_FULL) begin
         sdo_nxt = rd_byte_r[3'(~cnt_r[2:0])];
      end
   end

   always_ff @(negedge link.sck or posedge link.scs_n) begin
      if (link.scs_n) begin
         sdo_r <= 1'b0;
         oe_r <= 1'b0;
      end else begin
         sdo_r <= sdo_nxt;
         oe_r <= oe_nxt;
      end
   end

   assign link.sdo = sdo_r;
   assign link.sdo_oe = oe_r;

   // ****************************************
   // system side: crossing, snapshot, strobes
   // ****************************************
   assign exec = scs_s2_r && (tgl_s2_r != seen_r);

   always_comb begin
      seen_nxt = seen_r;
      fifo_snap_nxt = fifo_snap_r;
      for (int i = 0; i < NREG; i++) begin
         snap_nxt[i] = snap_r[i];
      end
      // frozen while a frame runs; reloaded from rd_regs and rd_fifo while select is high
      if (scs_s2_r) begin
         for (int i = 0; i < NREG; i++) begin
            snap_nxt[i] = rd_regs[i*BYTE_W +: BYTE_W];
         end
         fifo_snap_nxt = rd_fifo;
      end
      wr_stb_nxt = 1'b0;
      rd_stb_nxt = 1'b0;
      acc_reg_nxt = acc_reg_r;
      acc_addr_nxt = acc_addr_r;
      wr_data_nxt = wr_data_r;
      if (exec) begin
         seen_nxt = tgl_s2_r;
         if (cmd_valid(cmd_r)) begin
            acc_reg_nxt = cmd_r[CMD_REG_BIT];
            acc_addr_nxt = cmd_r[ADDR_W-1:0];
            if (cmd_is_write(cmd_r)) begin
               wr_stb_nxt = 1'b1;
               wr_data_nxt = dat_r;
            end else begin
               rd_stb_nxt = 1'b1;
            end
         end
      end
      int_cnt_nxt = int_cnt_r;
      if (core_evt) begin
         int_cnt_nxt = INT_TMR;
      end else if (int_cnt_r != 4'h0) begin
         int_cnt_nxt = int_cnt_r - 4'h1;
      end
      int_n_nxt = (int_cnt_nxt == 4'h0);
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         scs_s1_r <= 1'b1;
         scs_s2_r <= 1'b1;
         tgl_s1_r <= 1'b0;
         tgl_s2_r <= 1'b0;
         seen_r <= 1'b0;
         for (int i = 0; i < NREG; i++) begin
            snap_r[i] <= 8'h00;
         end
         fifo_snap_r <= 8'h00;
         wr_stb_r <= 1'b0;
         rd_stb_r <= 1'b0;
         acc_reg_r <= 1'b0;
         acc_addr_r <= '0;
         wr_data_r <= 8'h00;
         int_cnt_r <= 4'h0;
         int_n_r <= 1'b1;
      end else begin
         scs_s1_r <= link.scs_n;
         scs_s2_r <= scs_s1_r;
         tgl_s1_r <= tgl_r;
         tgl_s2_r <= tgl_s1_r;
         seen_r <= seen_nxt;
         for (int i = 0; i < NREG; i++) begin
            snap_r[i] <= snap_nxt[i];
         end
         fifo_snap_r <= fifo_snap_nxt;
         wr_stb_r <= wr_stb_nxt;
         rd_stb_r <= rd_stb_nxt;
         acc_reg_r <= acc_reg_nxt;
         acc_addr_r <= acc_addr_nxt;
         wr_data_r <= wr_data_nxt;
         int_cnt_r <= int_cnt_nxt;
         int_n_r <= int_n_nxt;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign wr_stb = wr_stb_r;
   assign rd_stb = rd_stb_r;
   assign acc_reg = acc_reg_r;
   assign acc_addr = acc_addr_r;
   assign wr_data = wr_data_r;
   assign link.int_n = int_n_r;

endmodule

// >>> hdl/usp_host_end.sv
`timescale 1ns/1ps
module usp_host_end (
   // system clock and reset
   input wire logic clk,
   input wire logic reset,
   // link to the device
   usp_if.host link,
   // request
   input wire logic start,
   input wire logic [usp_pkg::BYTE_W-1:0] cmd,
   input wire logic [usp_pkg::BYTE_W-1:0] wdata,
   input wire logic abort,
   output logic ready,
   // answer
   output logic done,
   output logic [usp_pkg::BYTE_W-1:0] rdata,
   output logic irq
);
   import usp_pkg::*;

   // ****************************************
   // declarations
   // ****************************************
   usp_hstate_type st_r;
   usp_hstate_type st_nxt;
   logic [7:0] tmr_r;
   logic [7:0] tmr_nxt;
   logic [4:0] bit_r;
   logic [4:0] bit_nxt;
   logic sck_r;
   logic sck_nxt;
   logic scs_n_r;
   logic scs_n_nxt;
   logic sdi_r;
   logic sdi_nxt;
   logic [15:0] tx_r;
   logic [15:0] tx_nxt;
   logic [7:0] rx_r;
   logic [7:0] rx_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic done_r;
   logic done_nxt;
   logic sdo_s1_r;
   logic sdo_s2_r;
   logic int_s1_r;
   logic int_s2_r;
   logic int_s3_r;
   logic irq_r;

   // ****************************************
   // sequencer
   // ****************************************
   always_comb begin
      st_nxt = st_r;
      tmr_nxt = tmr_r;
      bit_nxt = bit_r;
      sck_nxt = sck_r;
      scs_n_nxt = scs_n_r;
      sdi_nxt = sdi_r;
      tx_nxt = tx_r;
      rx_nxt = rx_r;
      rdata_nxt = rdata_r;
      done_nxt = 1'b0;
      if (tmr_r != 8'h00) begin
         tmr_nxt = tmr_r - 8'h01;
      end
      unique case (st_r)
         HS_IDLE: begin
            if (start) begin
               tx_nxt = {cmd, wdata};
               scs_n_nxt = 1'b0;
               sck_nxt = 1'b0;
               sdi_nxt = cmd[7];
               bit_nxt = 5'h00;
               tmr_nxt = CSS_TMR;
               st_nxt = HS_SETUP;
            end
         end
         HS_SETUP: begin
            if (tmr_r == 8'h00) begin
               st_nxt = HS_SHIFT;
               tmr_nxt = HALF_TMR;
               sck_nxt = 1'b1;
               rx_nxt = {rx_r[6:0], sdo_s2_r};
            end
         end
         HS_SHIFT: begin
            if (tmr_r == 8'h00) begin
               tmr_nxt = HALF_TMR;
               if (!sck_r) begin
                  sck_nxt = 1'b1;
                  rx_nxt = {rx_r[6:0], sdo_s2_r};
               end else begin
                  sck_nxt = 1'b0;
                  bit_nxt = bit_r + 5'h01;
                  tx_nxt = {tx_r[14:0], 1'b0};
                  sdi_nxt = tx_r[14];
                  if (bit_r == CNT_LAST) begin
                     st_nxt = HS_HOLD;
                  end
               end
            end
         end
         HS_HOLD: begin
            if (tmr_r == 8'h00) begin
               scs_n_nxt = 1'b1;
               done_nxt = 1'b1;
               rdata_nxt = rx_r;
               tmr_nxt = CSW_TMR;
               st_nxt = HS_GAP;
            end
         end
         HS_GAP: begin
            if (tmr_r == 8'h00) begin
               st_nxt = HS_IDLE;
            end
         end
         default: begin
            st_nxt = HS_IDLE;
            scs_n_nxt = 1'b1;
            sck_nxt = 1'b0;
         end
      endcase
      if (abort && (st_r == HS_SETUP || st_r == HS_SHIFT ||
            st_r == HS_HOLD)) begin
         scs_n_nxt = 1'b1;
         sck_nxt = 1'b0;
         done_nxt = 1'b0;
         tmr_nxt = CSW_TMR;
         st_nxt = HS_GAP;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st_r <= HS_IDLE;
         tmr_r <= 8'h00;
         bit_r <= 5'h00;
         sck_r <= 1'b0;
         scs_n_r <= 1'b1;
         sdi_r <= 1'b0;
         tx_r <= 16'h0000;
         rx_r <= 8'h00;
         rdata_r <= 8'h00;
         done_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         tmr_r <= tmr_nxt;
         bit_r <= bit_nxt;
         sck_r <= sck_nxt;
         scs_n_r <= scs_n_nxt;
         sdi_r <= sdi_nxt;
         tx_r <= tx_nxt;
         rx_r <= rx_nxt;
         rdata_r <= rdata_nxt;
         done_r <= done_nxt;
      end
   end

   // ****************************************
   // pin synchronisers and interrupt edge
   // ****************************************
   always_ff @(posedge clk) begin
      if (reset) begin
         sdo_s1_r <= 1'b1;
         sdo_s2_r <= 1'b1;
         int_s1_r <= 1'b1;
         int_s2_r <= 1'b1;
         int_s3_r <= 1'b1;
         irq_r <= 1'b0;
      end else begin
         sdo_s1_r <= link.sdo_line;
         sdo_s2_r <= sdo_s1_r;
         int_s1_r <= link.int_n;
         int_s2_r <= int_s1_r;
         int_s3_r <= int_s2_r;
         irq_r <= int_s3_r && !int_s2_r;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign link.scs_n = scs_n_r;
   assign link.sck = sck_r;
   assign link.sdi = sdi_r;
   assign ready = (st_r == HS_IDLE);
   assign done = done_r;
   assign rdata = rdata_r;
   assign irq = irq_r;

endmodule

// >>> verification/usp_asserts.sv
`timescale 1ns/1ps
module usp_asserts (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // link wires
   input wire logic scs_n,
   input wire logic sck,
   input wire logic sdi,
   input wire logic sdo,
   input wire logic sdo_oe,
   input wire logic int_n,
   input wire logic sdo_line
);

   // ****************************************
   // rising clock count per frame
   // ****************************************
   logic sck_d_r;
   logic sck_d_nxt;
   logic [4:0] cnt_r;
   logic [4:0] cnt_nxt;

   always_comb begin
      sck_d_nxt = sck;
      cnt_nxt = cnt_r;
      if (scs_n) begin
         cnt_nxt = 5'h00;
      end else if (sck && !sck_d_r && cnt_r != 5'h1F) begin
         cnt_nxt = cnt_r + 5'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         sck_d_r <= 1'b0;
         cnt_r <= 5'h00;
      end else begin
         sck_d_r <= sck_d_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // ****************************************
   // properties
   // ****************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   idle_released_a:
      assert property (scs_n |-> !sdo_oe) else $error("sdo driven");
   idle_line_high_a:
      assert property (scs_n |-> sdo_line) else $error("line not high");
   sdo_on_fall_a:
      assert property (!scs_n && $past(!scs_n) && $changed(sdo) |-> $fell(sck))
      else $error("sdo moved off fall");
   oe_on_fall_a:
      assert property ($rose(sdo_oe) |-> $fell(sck)) else $error("oe off fall");
   clk_idle_low_a:
      assert property (scs_n |-> !sck) else $error("clock runs idle");
   sel_setup_a:
      assert property ($rose(sck) && cnt_r == 5'h00 |-> $past(!scs_n, 4))
      else $error("select setup short");
   sdi_stable_a:
      assert property ($rose(sck) |-> $stable(sdi)) else $error("sdi moved");
   sixteen_max_a:
      assert property ($rose(scs_n) |-> cnt_r <= 5'h10)
      else $error("too many bits");
   gap_high_a:
      assert property ($rose(scs_n) |-> scs_n [*8]) else $error("gap short");
   int_pulse_a:
      assert property ($fell(int_n) |=> !int_n [*7]) else $error("irq short");

   full_frame_c: cover property ($rose(scs_n) && cnt_r == 5'h10);
   cut_frame_c: cover property ($rose(scs_n) && cnt_r < 5'h10);
   int_pulse_c: cover property ($fell(int_n));

endmodule

// >>> verification/test_uart_module_spi_slave_port.sv
`timescale 1ns/1ps
module test_uart_module_spi_slave_port;
   import usp_pkg::*;

   // ****************************************
   // signals and instances
   // ****************************************
   logic clk = 1'b0;
   logic reset;
   logic start, abort, ready, done, irq, core_evt;
   logic [7:0] cmd, wdata, rdata, rd_fifo;
   logic [63:0] rd_regs;
   logic wr_stb_a, rd_stb_a, acc_reg_a, wr_stb_b, rd_stb_b;
   logic [2:0] acc_addr_a;
   logic [7:0] wr_data_a, wr_data_b;
   int bad_count = 0;
   int n_checks = 0;
   int nw [2] = '{0, 0};
   int nr [2] = '{0, 0};

   usp_if link_a();
   usp_if link_b();

   usp_host_end u_usp_host_end (.clk(clk), .reset(reset), .link(link_a),
      .start(start), .cmd(cmd), .wdata(wdata), .abort(abort),
      .ready(ready), .done(done), .rdata(rdata), .irq(irq));
   usp_dev_end u_usp_dev_end (.clk(clk), .reset(reset), .link(link_a),
      .wr_stb(wr_stb_a), .rd_stb(rd_stb_a), .acc_reg(acc_reg_a),
      .acc_addr(acc_addr_a), .wr_data(wr_data_a), .rd_regs(rd_regs),
      .rd_fifo(rd_fifo), .core_evt(core_evt));
   usp_dev_end u_usp_dev_end_b (.clk(clk), .reset(reset), .link(link_b),
      .wr_stb(wr_stb_b), .rd_stb(rd_stb_b), .acc_reg(), .acc_addr(),
      .wr_data(wr_data_b), .rd_regs(rd_regs), .rd_fifo(rd_fifo),
      .core_evt(core_evt));
   usp_asserts u_usp_asserts (.clk(clk), .reset(reset),
      .scs_n(link_a.scs_n), .sck(link_a.sck), .sdi(link_a.sdi),
      .sdo(link_a.sdo), .sdo_oe(link_a.sdo_oe), .int_n(link_a.int_n),
      .sdo_line(link_a.sdo_line));

   always #12.5 clk = ~clk;

   always @(posedge clk) begin
      nw[0] += int'(wr_stb_a === 1'b1);
      nr[0] += int'(rd_stb_a === 1'b1);
      nw[1] += int'(wr_stb_b === 1'b1);
      nr[1] += int'(rd_stb_b === 1'b1);
   end

   // ****************************************
   // helpers
   // ****************************************
   task test_done;
      $display("checks %0d bad %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task tick;
      @(posedge clk);
      #1;
   endtask

   function automatic logic [7:0] exp_rd(input logic [7:0] c);
      if (c[7:5] != 3'h0) return 8'h00;
      return c[4] ? rd_regs[8*c[2:0] +: 8] : rd_fifo;
   endfunction

   task automatic launch(input logic [7:0] c, input logic [7:0] d);
      int k;
      k = 0;
      while (ready !== 1'b1 && k < 400) begin
         tick();
         k++;
      end
      @(posedge clk);
      start <= 1'b1;
      cmd <= c;
      wdata <= d;
      @(posedge clk);
      start <= 1'b0;
   endtask

   task automatic frame(input logic [7:0] c, input logic [7:0] d);
      int w0, r0, k;
      logic ok;
      w0 = nw[0];
      r0 = nr[0];
      ok = (c[7:5] == 3'h0);
      launch(c, d);
      k = 0;
      do begin
         tick();
         k++;
      end while (done !== 1'b1 && k < 400);
      chk({7'h0, done}, 8'h01);
      repeat (8) tick();
      chk(8'(nw[0] - w0), {7'h0, ok & c[3]});
      chk(8'(nr[0] - r0), {7'h0, ok & !c[3]});
      if (ok) begin
         if (c[3]) chk(wr_data_a, d);
         chk({7'h0, acc_reg_a}, {7'h0, c[4]});
         if (c[4]) chk({5'h0, acc_addr_a}, {5'h0, c[2:0]});
      end
      if (!c[3]) chk(rdata, exp_rd(c));
      @(posedge clk);
      rd_regs <= {$urandom, $urandom};
      rd_fifo <= 8'($urandom);
   endtask

   task automatic cut(input int n);
      int w0, seen;
      w0 = nw[0];
      seen = 0;
      launch(8'h1A, 8'($urandom));
      repeat (n) @(posedge clk);
      abort <= 1'b1;
      @(posedge clk);
      abort <= 1'b0;
      repeat (160) begin
         tick();
         seen += int'(done === 1'b1);
      end
      chk(8'(seen), 8'h00);
      chk(8'(nw[0] - w0), 8'h00);
   endtask

   task automatic bang(input logic [15:0] w, input int n,
                       output logic [7:0] got);
      int i, w0;
      got = 8'h00;
      w0 = nw[1];
      link_b.scs_n = 1'b0;
      #100;
      for (i = 0; i < n; i++) begin
         link_b.sdi = w[15-i];
         #24;
         link_b.sck = 1'b1;
         got = {got[6:0], link_b.sdo_line};
         #24;
         link_b.sck = 1'b0;
      end
      #300;
      chk(8'(nw[1] - w0), 8'h00);
      link_b.scs_n = 1'b1;
      link_b.sdi = ~link_b.sdi;
      #500;
      chk({7'h0, link_b.sdo_line}, 8'h01);
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      logic [7:0] corner [5];
      logic [7:0] c, got;
      int m, k;
      corner = '{8'h00, 8'h17, 8'h08, 8'h1F, 8'hE8};
      // edge at time zero clears the link side flops
      reset <= 1'b1;
      void'($urandom(32'h509ebf3e));
      start = 1'b0;
      abort = 1'b0;
      cmd = 8'h00;
      wdata = 8'h00;
      core_evt = 1'b0;
      rd_regs = {$urandom, $urandom};
      rd_fifo = 8'($urandom);
      link_b.scs_n <= 1'b1;
      link_b.sck = 1'b0;
      link_b.sdi = 1'b0;
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      foreach (corner[i]) frame(corner[i], 8'($urandom));
      repeat (12) begin
         c = 8'($urandom) & 8'h3F;
         frame(c, 8'($urandom));
      end
      cut(2);
      cut(60);
      cut(120);
      frame(8'h11, 8'h00);
      repeat (2) begin
         k = 0;
         @(posedge clk);
         core_evt <= 1'b1;
         @(posedge clk);
         core_evt <= 1'b0;
         repeat (20) begin
            tick();
            k += int'(irq === 1'b1);
         end
         chk(8'(k), 8'h01);
      end
      m = nw[1];
      bang({8'h1D, 8'h3C}, 16, got);
      chk(8'(nw[1] - m), 8'h01);
      chk(wr_data_b, 8'h3C);
      bang({8'h0D, 8'h77}, 10, got);
      chk(8'(nw[1] - m), 8'h01);
      bang({8'h15, 8'h00}, 16, got);
      chk(got, exp_rd(8'h15));
      chk(8'(nr[1]), 8'h01);
      test_done;
   end

   initial begin
      #600000;
      bad_count++;
      test_done;
   end

endmodule
